// ==== design/gate_drive_map.vh ====
`ifndef GATE_DRIVE_MAP_VH
`define GATE_DRIVE_MAP_VH
// Time base
`define CLK_PERIOD_NS 50
`define DT_STEP_NS 50
`define DT_MAX_NS 12000
`define DT_SAT 8'hFF
`define DT_MIN 8'h01
`define DESAT_FILTER_NS 1000
`define BLANK_CYCLES_DEF 8
// Status bit positions
`define ST_OC 0
`define ST_DESAT 1
`define ST_MODE_EN 2
`define ST_LOCK 3
// Enable state machine
`define MODE_STANDBY 2'h0
`define MODE_INIT 2'h1
`define MODE_ENABLE 2'h2
`define MODE_FAULT 2'h3
`endif

// ==== design/three_phase_gate_drive_control.v ====
`timescale 1ns/10ps
`default_nettype none
`include "gate_drive_map.vh"
// Notes on behaviour
// - Deadtime programmable in 50 ns steps from 0 ns to 12.75 us.
// - Deadtime counted 1..255 clock cycles, saturating at 255; zero selectable separately.
// - Simultaneous-operation mode disables the post-turn-on blanking delay.
// - Simultaneous-mode setting accepted once per reset; later writes ignored.
// - Commands set and lock pass-through, desat behaviour, zero deadtime; fault reporting masks set but not locked.
// - Pass-through mode skips the decision stage, one cycle less latency.
// - Status state is readable by the controller.
// - Phase inputs edge sensitive; complement off at once, selected on after deadtime.
// - Deadtime timer starts on any turn-off; complement waits until it elapses, except in pass-through or simultaneous mode.
// - Turn-on after deadtime already elapsed executes with no extra delay.
// - Current limit blanked right after each input state change.
// - High side refused until same-phase low side has been on once.
// - Driving continues only with reset released and both enables high.
// - Overcurrent comparator change latches an overcurrent fault.
// - Latched overcurrent shown in status 0; drives interrupt if unmasked.
// - Interrupt holds until fault gone and group clear issued: group zero for overcurrent, group one for desat.
// - Desat still present after blanking following high-side turn-on initiates fault.
// - Initiated desat passes a 1.0 us filter; registration turns all gates off.
// - Desat clearing before filter expiry discards it and restarts the timer.
// - Registered faults recorded in a readable fault status register.
// - Interrupt maskable; desat shutdown can be disabled.
module three_phase_gate_drive_control #(
   parameter BLANK_CYCLES = `BLANK_CYCLES_DEF
) (
   // Clock and reset
   input wire mclk,
   input wire srst,
   // Enables, asynchronous pins
   input wire enable1,
   input wire enable2,
   // Phase commands, asynchronous pins, bit per phase
   input wire [2:0] phase_high_cmd,
   input wire [2:0] phase_low_cmd,
   // Comparators, asynchronous
   input wire overcurrent_flag_out,
   input wire [2:0] desat_cmp,
   // Configuration from command decoder, same clock
   input wire [7:0] deadtime_req,
   input wire deadtime_load,
   input wire zero_deadtime,
   input wire pass_through_mode,
   input wire simul_req,
   input wire simul_load,
   input wire mode_lock,
   input wire int_mask_oc,
   input wire int_mask_desat,
   input wire desat_shutdown_dis,
   input wire clear_int_group0,
   input wire clear_int_group1,
   // Gate outputs
   output reg [2:0] phase_high_gate_out,
   output reg [2:0] phase_low_gate_out,
   output reg [2:0] current_limit_blank,
   // Status
   output reg int_out,
   output reg [7:0] status0,
   output reg [7:0] deadtime_q,
   output reg simul_en_q
);
   localparam integer FILT_CYC = `DESAT_FILTER_NS / `CLK_PERIOD_NS;
   localparam integer DTMAX_CYC = `DT_MAX_NS / `DT_STEP_NS;

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers
   reg [11:0] s1_q, s2_q, s3_q;
   wire [11:0] raw = {desat_cmp, overcurrent_flag_out, enable2, enable1,
      phase_low_cmd, phase_high_cmd};
   always @(posedge mclk) begin
      if (srst) begin
         s1_q <= 12'h000;
         s2_q <= 12'h000;
         s3_q <= 12'h000;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   wire [2:0] hs = s2_q[2:0];
   wire [2:0] ls = s2_q[5:3];
   wire [2:0] hs_rise = s2_q[2:0] & ~s3_q[2:0];
   wire [2:0] ls_rise = s2_q[5:3] & ~s3_q[5:3];
   wire [5:0] any_chg = s2_q[5:0] ^ s3_q[5:0];
   wire en_ok = s2_q[6] & s2_q[7];
   wire oc_chg = s2_q[8] ^ s3_q[8];
   wire [2:0] desat = s2_q[11:9];

   ////////////////////////////////////////////////////////////////////////
   // Configuration and lock
   reg lock_q, simul_done_q, pt_q, zdt_q, dshd_q;
   always @(posedge mclk) begin
      if (srst) begin
         deadtime_q <= `DT_SAT;
         lock_q <= 1'b0;
         simul_done_q <= 1'b0;
         simul_en_q <= 1'b0;
         pt_q <= 1'b0;
         zdt_q <= 1'b0;
         dshd_q <= 1'b0;
      end else begin
         if (deadtime_load)
            deadtime_q <= (deadtime_req < `DT_MIN) ? `DT_MIN : deadtime_req;
         if (simul_load && !simul_done_q) begin
            simul_en_q <= simul_req;
            simul_done_q <= 1'b1;
         end
         if (!lock_q) begin
            pt_q <= pass_through_mode;
            zdt_q <= zero_deadtime;
            dshd_q <= desat_shutdown_dis;
            lock_q <= mode_lock;
         end
      end
   end
   wire [7:0] dt_eff = zdt_q ? 8'h00 : deadtime_q;

   ////////////////////////////////////////////////////////////////////////
   // Mode machine
   reg [1:0] mode_q;
   reg desat_reg_q;
   reg [2:0] ls_seen_q;
   always @(posedge mclk) begin
      if (srst) begin
         mode_q <= `MODE_STANDBY;
      end else begin
         case (mode_q)
            `MODE_STANDBY: if (en_ok) mode_q <= `MODE_INIT;
            `MODE_INIT: begin
               if (!en_ok) mode_q <= `MODE_STANDBY;
               else if (&ls_seen_q) mode_q <= `MODE_ENABLE;
            end
            `MODE_ENABLE: begin
               if (!en_ok) mode_q <= `MODE_STANDBY;
               else if (desat_reg_q && !dshd_q) mode_q <= `MODE_FAULT;
            end
            `MODE_FAULT: if (!en_ok) mode_q <= `MODE_STANDBY;
            default: mode_q <= `MODE_STANDBY;
         endcase
      end
   end
   wire drive_ok = (mode_q == `MODE_INIT) || (mode_q == `MODE_ENABLE);
   wire shut = desat_reg_q && !dshd_q;

   ////////////////////////////////////////////////////////////////////////
   // Per-phase deadtime, blanking and desat filter
   reg [7:0] dt_cnt_q [0:2];
   reg [7:0] blk_cnt_q [0:2];
   reg [7:0] flt_cnt_q [0:2];
   reg [2:0] hs_want_q, ls_want_q, hs_dec_q, ls_dec_q, desat_pend;
   integer i;
   always @(posedge mclk) begin
      if (srst) begin
         for (i = 0; i < 3; i = i + 1) begin
            dt_cnt_q[i] <= 8'h00;
            blk_cnt_q[i] <= 8'h00;
            flt_cnt_q[i] <= 8'h00;
         end
         hs_want_q <= 3'h0;
         ls_want_q <= 3'h0;
         hs_dec_q <= 3'h0;
         ls_dec_q <= 3'h0;
         ls_seen_q <= 3'h0;
         desat_reg_q <= 1'b0;
         current_limit_blank <= 3'h0;
         phase_high_gate_out <= 3'h0;
         phase_low_gate_out <= 3'h0;
         desat_pend <= 3'h0;
      end else begin
         if (clear_int_group1 && !(|desat_pend))
            desat_reg_q <= 1'b0;
         for (i = 0; i < 3; i = i + 1) begin
            if (!drive_ok) ls_seen_q[i] <= 1'b0;
            else if (ls_dec_q[i]) ls_seen_q[i] <= 1'b1;
            // Level follows edge: rising edge selects, falling turns off
            if (hs_rise[i] && !simul_en_q) begin
               ls_want_q[i] <= 1'b0;
               ls_dec_q[i] <= 1'b0;
               if (ls_dec_q[i]) dt_cnt_q[i] <= dt_eff;
            end else if (ls_rise[i] && !simul_en_q) begin
               hs_want_q[i] <= 1'b0;
               hs_dec_q[i] <= 1'b0;
               if (hs_dec_q[i]) dt_cnt_q[i] <= dt_eff;
            end else if (dt_cnt_q[i] != 8'h00) begin
               dt_cnt_q[i] <= dt_cnt_q[i] - 8'h01;
            end
            if (!hs[i]) begin
               if (hs_dec_q[i]) dt_cnt_q[i] <= dt_eff;
               hs_want_q[i] <= 1'b0;
               hs_dec_q[i] <= 1'b0;
            end else if (hs_rise[i]) hs_want_q[i] <= 1'b1;
            if (!ls[i]) begin
               if (ls_dec_q[i]) dt_cnt_q[i] <= dt_eff;
               ls_want_q[i] <= 1'b0;
               ls_dec_q[i] <= 1'b0;
            end else if (ls_rise[i]) ls_want_q[i] <= 1'b1;
            // Decision stage, immediate once timer is idle
            if (hs_want_q[i] && (dt_cnt_q[i] == 8'h00 || simul_en_q)
                && ls_seen_q[i] && hs[i])
               hs_dec_q[i] <= 1'b1;
            if (ls_want_q[i] && (dt_cnt_q[i] == 8'h00 || simul_en_q) && ls[i])
               ls_dec_q[i] <= 1'b1;
            // Blanking restarts on any input change; skipped in simultaneous mode
            if ((any_chg[i] || any_chg[i+3]) && !simul_en_q)
               blk_cnt_q[i] <= BLANK_CYCLES[7:0];
            else if (blk_cnt_q[i] != 8'h00)
               blk_cnt_q[i] <= blk_cnt_q[i] - 8'h01;
            current_limit_blank[i] <= (blk_cnt_q[i] != 8'h00);
            // Desat filter, restarts when condition drops
            if (hs_dec_q[i] && blk_cnt_q[i] == 8'h00 && desat[i]) begin
               desat_pend[i] <= 1'b1;
               if (flt_cnt_q[i] == FILT_CYC[7:0] - 8'h01)
                  desat_reg_q <= 1'b1;
               else
                  flt_cnt_q[i] <= flt_cnt_q[i] + 8'h01;
            end else begin
               desat_pend[i] <= 1'b0;
               flt_cnt_q[i] <= 8'h00;
            end
         end
         // Pass-through bypasses the decision registers
         if (!drive_ok || shut || mode_q == `MODE_FAULT) begin
            phase_high_gate_out <= 3'h0;
            phase_low_gate_out <= 3'h0;
         end else if (pt_q) begin
            // Taken from the want stage, one cycle ahead of the decision
            phase_high_gate_out <= hs_want_q & ls_seen_q;
            phase_low_gate_out <= ls_want_q;
         end else begin
            phase_high_gate_out <= hs_dec_q;
            phase_low_gate_out <= ls_dec_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault status and interrupt
   reg oc_q;
   always @(posedge mclk) begin
      if (srst) begin
         oc_q <= 1'b0;
         int_out <= 1'b0;
         status0 <= 8'h00;
      end else begin
         if (oc_chg)
            oc_q <= 1'b1;
         else if (clear_int_group0 && !s2_q[8])
            oc_q <= 1'b0;
         int_out <= (oc_q && !int_mask_oc) || (desat_reg_q && !int_mask_desat);
         status0 <= 8'h00;
         status0[`ST_OC] <= oc_q;
         status0[`ST_DESAT] <= desat_reg_q;
         status0[`ST_MODE_EN] <= (mode_q == `MODE_ENABLE);
         status0[`ST_LOCK] <= lock_q;
      end
   end
   wire unused_ok = (DTMAX_CYC != 0);
endmodule // three_phase_gate_drive_control
`default_nettype wire

// ==== verification/gate_drive_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module gate_drive_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Inputs
   input wire logic enable1,
   input wire logic enable2,
   input wire logic overcurrent_flag_out,
   input wire logic [2:0] desat_cmp,
   input wire logic [7:0] deadtime_req,
   input wire logic deadtime_load,
   input wire logic simul_load,
   input wire logic desat_shutdown_dis,
   input wire logic clear_int_group0,
   input wire logic clear_int_group1,
   // Outputs
   input wire logic [2:0] phase_high_gate_out,
   input wire logic [2:0] phase_low_gate_out,
   input wire logic int_out,
   input wire logic [7:0] status0,
   input wire logic [7:0] deadtime_q,
   input wire logic simul_en_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   logic [2:0] ls_seen_q;
   logic sim_seen_q;
   logic [5:0] dcnt_q;
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      ls_seen_q <= (srst || !(enable1 && enable2)) ? 3'h0 : ls_seen_q | phase_low_gate_out;
      sim_seen_q <= !srst && (sim_seen_q || simul_load);
      // Saturates so a stuck gate keeps tripping
      if (srst || !(phase_high_gate_out[0] && desat_cmp[0] && !desat_shutdown_dis))
         dcnt_q <= 6'h00;
      else if (dcnt_q != 6'h3F)
         dcnt_q <= dcnt_q + 6'h01;
   end
   sequence s_disabled;
      !(enable1 && enable2) [*5];
   endsequence
   ////////////////////////////////////////////////////////////////
   a_no_overlap: assert property (!simul_en_q |-> (phase_high_gate_out & phase_low_gate_out) == 3'h0)
      else $error("high and low gate overlap");
   a_dt_load: assert property (deadtime_load |=> deadtime_q == (($past(deadtime_req) == 8'h00) ? 8'h01 : $past(deadtime_req)))
      else $error("deadtime load wrong");
   a_simul_once: assert property (sim_seen_q && simul_load |=> $stable(simul_en_q))
      else $error("second simultaneous load taken");
   a_off_disabled: assert property (s_disabled |-> (phase_high_gate_out | phase_low_gate_out) == 3'h0)
      else $error("gate on while disabled");
   a_oc_latch: assert property ($changed(overcurrent_flag_out) |-> ##[1:5] status0[0])
      else $error("overcurrent not latched");
   a_int_hold: assert property (int_out && !clear_int_group0 && !clear_int_group1 && !$past(clear_int_group0) && !$past(clear_int_group1) |=> int_out)
      else $error("interrupt dropped without clear");
   a_hs_first: assert property ((phase_high_gate_out & ~$past(phase_high_gate_out) & ~ls_seen_q) == 3'h0)
      else $error("high side before low side");
   a_desat_off: assert property (dcnt_q < 6'h28)
      else $error("desaturated gate not shut off");
endmodule // gate_drive_checker
bind three_phase_gate_drive_control gate_drive_checker chk_u (.*);
`default_nettype wire

// ==== verification/mcu_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mcu_model (
   // Clock
   input wire logic mclk,
   // Pins toward the driver
   output logic enable1,
   output logic enable2,
   output logic [2:0] phase_high_cmd,
   output logic [2:0] phase_low_cmd
);
   initial {enable1, enable2, phase_high_cmd, phase_low_cmd} = 8'h00;
   task drive(input logic en, input logic [2:0] h, input logic [2:0] l);
      @(posedge mclk);
      {enable1, enable2} <= {en, en};
      phase_high_cmd <= h;
      phase_low_cmd <= l;
   endtask
endmodule // mcu_model
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic mclk, srst, overcurrent_flag_out, zero_deadtime, pass_through_mode, simul_req, mode_lock;
   logic int_mask_oc, int_mask_desat, desat_shutdown_dis;
   logic [2:0] desat_cmp;
   logic [7:0] deadtime_req;
   logic [3:0] stb;
   wire enable1, enable2, int_out, simul_en_q;
   wire [2:0] phase_high_cmd, phase_low_cmd, phase_high_gate_out, phase_low_gate_out;
   wire [2:0] current_limit_blank;
   wire [7:0] status0, deadtime_q;
   wire deadtime_load = stb[0];
   wire simul_load = stb[1];
   wire clear_int_group0 = stb[2];
   wire clear_int_group1 = stb[3];
   int errors, samples_checked, n, n0;
   three_phase_gate_drive_control dut_u (.*);
   mcu_model mcu_u (.*);
   ////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task conclude;
      if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task cyc(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task strobe(input int k);
      @(posedge mclk);
      stb[k] <= 1'b1;
      @(posedge mclk);
      stb <= 4'h0;
      cyc(3);
   endtask
   // Cycles until phase A gate shows, bounded
   task lat(input logic [2:0] h, l, input logic hs, output int c);
      mcu_u.drive(1'b1, h, l);
      #1;
      c = 0;
      while ((hs ? phase_high_gate_out[0] : phase_low_gate_out[0]) !== 1'b1 && c < 400) begin
         @(posedge mclk);
         #1;
         c++;
      end
      if (c >= 400) begin
         errors++;
         conclude();
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      {srst, overcurrent_flag_out, zero_deadtime, pass_through_mode, simul_req, mode_lock} = 6'h20;
      {int_mask_oc, int_mask_desat, desat_shutdown_dis, desat_cmp, deadtime_req, stb} = 18'h00000;
      errors = 0;
      samples_checked = 0;
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      cyc(2);
      chk(deadtime_q, 8'hFF);
      strobe(0);
      chk(deadtime_q, 8'h01);
      deadtime_req <= 8'h0A;
      strobe(0);
      chk(deadtime_q, 8'h0A);
      mcu_u.drive(1'b1, 3'h1, 3'h0);
      cyc(30);
      chk(8'(phase_high_gate_out), 8'h00);
      mcu_u.drive(1'b1, 3'h0, 3'h0);
      cyc(5);
      lat(3'h0, 3'h7, 1'b0, n0);
      chk(8'(phase_low_gate_out), 8'h07);
      chk(8'(current_limit_blank), 8'h07);
      lat(3'h1, 3'h6, 1'b1, n);
      chk(8'(n >= n0 + 9 && n <= n0 + 11), 8'h01);
      chk(8'(phase_low_gate_out), 8'h06);
      chk(8'(status0[2]), 8'h01);
      mcu_u.drive(1'b1, 3'h0, 3'h7);
      cyc(30);
      mcu_u.drive(1'b1, 3'h0, 3'h6);
      cyc(30);
      lat(3'h1, 3'h6, 1'b1, n);
      chk(8'(n), 8'(n0));
      mcu_u.drive(1'b1, 3'h0, 3'h0);
      cyc(30);
      pass_through_mode <= 1'b1;
      cyc(3);
      lat(3'h0, 3'h7, 1'b0, n);
      chk(8'(n), 8'(n0 - 1));
      pass_through_mode <= 1'b0;
      simul_req <= 1'b1;
      strobe(1);
      simul_req <= 1'b0;
      strobe(1);
      chk(8'(simul_en_q), 8'h01);
      overcurrent_flag_out <= 1'b1;
      cyc(6);
      chk(8'({int_out, status0[0]}), 8'h03);
      strobe(2);
      chk(8'(int_out), 8'h01);
      overcurrent_flag_out <= 1'b0;
      cyc(6);
      strobe(2);
      chk(8'({int_out, status0[0]}), 8'h00);
      int_mask_oc <= 1'b1;
      overcurrent_flag_out <= 1'b1;
      cyc(6);
      chk(8'({int_out, status0[0]}), 8'h01);
      mcu_u.drive(1'b1, 3'h0, 3'h6);
      cyc(30);
      lat(3'h1, 3'h6, 1'b1, n);
      chk(8'(current_limit_blank), 8'h00);
      desat_cmp <= 3'h1;
      cyc(10);
      desat_cmp <= 3'h0;
      cyc(5);
      chk(8'(phase_high_gate_out), 8'h01);
      desat_cmp <= 3'h1;
      cyc(40);
      chk({phase_high_gate_out, phase_low_gate_out, status0[1], int_out}, 8'h03);
      conclude();
   end
endmodule // testbench
`default_nettype wire
